// ==== ep_intr_defines.vh ====
// Register map, field positions, writable-bit masks and encodings of the endpoint interrupt block.
`ifndef EP_INTR_DEFINES_VH
`define EP_INTR_DEFINES_VH

`define ADDR_W               12
`define OFF_FIFO_EMPTY_MASK  12'h834
`define OFF_EACH_SUMMARY     12'h838
`define OFF_EACH_MASK        12'h83C
`define OFF_IN_MASK_BASE     12'h840
`define OFF_OUT_MASK_BASE    12'h880
`define OFF_EP0_IN_CTRL      12'h900
`define OFF_IN_STAT_BASE     12'h908
`define STAT_STRIDE_SH       5
`define WORD_SH              2

`define IN_MASK_BITS         32'h0000237F
`define OUT_MASK_BITS        32'h0000735F
`define STAT_BITS            32'h00007BFF

`define B_NOT_YET            14
`define B_NAK                13
`define B_BABBLE             12
`define B_DROPPED            11
`define B_BUF_UNAVAIL        9
`define B_UNDERRUN           8
`define B_FIFO_EMPTY         7
`define B_NAK_EFF            6
`define B_EP_DISABLED        1
`define B_XFER_DONE          0

`define C_ENABLE             31
`define C_DISABLE            30
`define C_SET_NAK            27
`define C_CLEAR_NAK          26
`define C_TX_FIFO            22
`define C_STALL              21
`define C_KIND_HI            19
`define C_KIND_LO            18
`define C_NAK_STATE          17
`define C_ACTIVE             15
`define C_NEXT_HI            14
`define C_NEXT_LO            11
`define C_MPS_HI             1
`define C_MPS_LO             0

`define KIND_CONTROL         2'h0
`define MPS_64               2'h0
`define MPS_32               2'h1
`define MPS_16               2'h2
`define MPS_8                2'h3

`endif

// ==== usb_device_ep_intr_ctrl.v ====
// Endpoint interrupt status, masking and endpoint-0 IN control for a USB device core.
`timescale 1ns/1ps
`include "ep_intr_defines.vh"
//
// Contract
// - Sixteen RW FIFO-empty mask bits, one per IN endpoint, gate FIFO-empty.
// - RO per-endpoint summary, OUT in 31:16, IN in 15:0; RW mask same.
// - Per-IN-endpoint mask word at base plus four times n.
// - Per-OUT-endpoint mask word at base plus four times n.
// - Enable set by software, cleared before disabled or done interrupt.
// - Disable set only while enabled; cleared and transmit stopped before interrupt.
// - Write-only set-NAK sets NAK state; SETUP may also set it.
// - Write-only clear-NAK clears NAK state.
// - Stall set by software only, cleared by SETUP, beats any NAK.
// - Endpoint kind field reads fixed control encoding.
// - NAK status bit shows NAK state; SETUP always acknowledged.
// - Endpoint-0 active bit always reads one.
// - Next-endpoint field is a plain RW field for fetch ordering.
// - Max packet code: 00=64, 01=32, 10=16, 11=8 bytes.
// - NYET sent sets bit 14; babble received sets bit 12.
// - NAK sent or received, or ISO zero-length packet, sets bit 13.
// - Dropped ISO OUT packet sets bit 11, unmasked, no summary effect.
// - Descriptor not ready sets bit 9.
// - Underrun or overflow/CRC error sets bit 8.
// - Transmit FIFO half or fully empty sets bit 7.
// - Enabled periodic IN endpoint sampling NAK set sets bit 6; clear-NAK clears.

module usb_device_ep_intr_ctrl #(
  parameter N_EP = 16
) (
  input  wire                  ref_clk_i,
  input  wire                  rst_b_i,
  input  wire [`ADDR_W-1:0]    addr_i,
  input  wire [31:0]           wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [31:0]           rdata_o,
  input  wire [N_EP*15-1:0]    ep_event_i,
  input  wire                  setup_rcvd_i,
  input  wire                  ep0_disable_done_i,
  input  wire                  ep0_xfer_done_i,
  input  wire                  ep0_periodic_i,
  output wire                  ep0_stall_o,
  output wire                  ep0_nak_o,
  output wire                  ep0_tx_allow_o,
  output wire [6:0]            ep0_max_bytes_o,
  output wire [3:0]            ep0_next_ep_o,
  output wire                  ep0_tx_fifo_o,
  output wire [N_EP-1:0]       in_ep_irq_o,
  output wire [N_EP-1:0]       out_ep_irq_o
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  reg  [15:0]          in_fifo_empty_mask_bits_q;
  reg  [31:0]          each_mask_q;
  reg  [31:0]          in_mask_q   [0:N_EP-1];
  reg  [31:0]          out_mask_q  [0:N_EP-1];
  reg  [31:0]          stat_q      [0:N_EP-1];
  reg                  ep_enable_bit_q;
  reg                  ep_disable_bit_q;
  reg                  nak_state_flag_q;
  reg                  stall_q;
  reg                  tx_fifo_select_q;
  reg  [3:0]           following_ep_field_q;
  reg  [1:0]           max_packet_size_code_q;
  wire [N_EP-1:0]      in_sum;
  wire [N_EP-1:0]      out_sum;
  reg  [6:0]           max_bytes;

  wire ctrl_wr = wr_i && (addr_i == `OFF_EP0_IN_CTRL);
  wire set_nak_strobe = ctrl_wr && wdata_i[`C_SET_NAK];
  wire clear_nak_strobe = ctrl_wr && wdata_i[`C_CLEAR_NAK];

  // ---------------------------------------------------------------------------
  // Endpoint-0 IN control
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ep_enable_bit_q        <= 1'b0;
      ep_disable_bit_q       <= 1'b0;
      nak_state_flag_q       <= 1'b0;
      stall_q                <= 1'b0;
      tx_fifo_select_q       <= 1'b0;
      following_ep_field_q   <= 4'h0;
      max_packet_size_code_q <= `MPS_64;
    end
    else
    begin
      // The core clears enable (and disable, on disable-done only) the cycle the event is posted, so
      // the status bit becomes visible no earlier than the cleared control.
      if (ep0_disable_done_i || ep0_xfer_done_i)
        ep_enable_bit_q <= 1'b0;
      else if (ctrl_wr && wdata_i[`C_ENABLE])
        ep_enable_bit_q <= 1'b1;
      if (ep0_disable_done_i)
        ep_disable_bit_q <= 1'b0;
      else if (ctrl_wr && wdata_i[`C_DISABLE] && ep_enable_bit_q)
        ep_disable_bit_q <= 1'b1;
      if (set_nak_strobe || setup_rcvd_i)
        nak_state_flag_q <= 1'b1;
      else if (clear_nak_strobe)
        nak_state_flag_q <= 1'b0;
      if (setup_rcvd_i)
        stall_q <= 1'b0;
      else if (ctrl_wr && wdata_i[`C_STALL])
        stall_q <= 1'b1;
      if (ctrl_wr)
      begin
        tx_fifo_select_q       <= wdata_i[`C_TX_FIFO];
        following_ep_field_q   <= wdata_i[`C_NEXT_HI:`C_NEXT_LO];
        max_packet_size_code_q <= wdata_i[`C_MPS_HI:`C_MPS_LO];
      end
    end
  end

  always @*
  begin
    case (max_packet_size_code_q)
      `MPS_64: max_bytes = 7'd64;
      `MPS_32: max_bytes = 7'd32;
      `MPS_16: max_bytes = 7'd16;
      `MPS_8:  max_bytes = 7'd8;
      default: max_bytes = 7'd64;
    endcase
  end

  assign ep0_stall_o     = stall_q;
  assign ep0_nak_o       = nak_state_flag_q && !stall_q;
  assign ep0_tx_allow_o  = ep_enable_bit_q && !ep_disable_bit_q
                           && !nak_state_flag_q && !stall_q;
  assign ep0_max_bytes_o = max_bytes;
  assign ep0_next_ep_o   = following_ep_field_q;
  assign ep0_tx_fifo_o   = tx_fifo_select_q;

  // ---------------------------------------------------------------------------
  // Per-endpoint masks and sticky status
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_EP; g = g + 1)
    begin : g_ep
      localparam [31:0] IN_M_FULL  = `OFF_IN_MASK_BASE  + (g << `WORD_SH);
      localparam [31:0] OUT_M_FULL = `OFF_OUT_MASK_BASE + (g << `WORD_SH);
      localparam [31:0] ST_FULL    = `OFF_IN_STAT_BASE  + (g << `STAT_STRIDE_SH);
      wire [`ADDR_W-1:0] in_m_addr  = IN_M_FULL[`ADDR_W-1:0];
      wire [`ADDR_W-1:0] out_m_addr = OUT_M_FULL[`ADDR_W-1:0];
      wire [`ADDR_W-1:0] st_addr    = ST_FULL[`ADDR_W-1:0];
      wire [31:0] ev = {17'h0, ep_event_i[g*15 +: 15]};
      wire [31:0] ev_all;
      wire        w1c = wr_i && (addr_i == st_addr);
      wire        nak_eff_set;

      // Only periodic endpoint 0 has a known enable here; others report raw.
      if (g == 0)
      begin : g_eff
        assign nak_eff_set = ep0_periodic_i && ep_enable_bit_q
                             && nak_state_flag_q;
      end
      else
      begin : g_raw
        assign nak_eff_set = ev[`B_NAK_EFF];
      end
      assign ev_all = {ev[31:`B_NAK_EFF+1], nak_eff_set, ev[`B_NAK_EFF-1:0]}
                      | ((g == 0) ? ({31'h0, ep0_xfer_done_i}
                      | {30'h0, ep0_disable_done_i, 1'b0}) : 32'h0);

      always @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          in_mask_q[g]  <= 32'h0;
          out_mask_q[g] <= 32'h0;
          stat_q[g]     <= 32'h0;
        end
        else
        begin
          if (wr_i && addr_i == in_m_addr)
            in_mask_q[g] <= wdata_i & `IN_MASK_BITS;
          if (wr_i && addr_i == out_m_addr)
            out_mask_q[g] <= wdata_i & `OUT_MASK_BITS;
          // A new event wins over a clear in the same cycle.
          stat_q[g] <= ((stat_q[g] & ~(w1c ? wdata_i : 32'h0))
                       | ev_all) & `STAT_BITS;
          if (g == 0 && clear_nak_strobe && !nak_eff_set)
            stat_q[g][`B_NAK_EFF] <= 1'b0;
        end
      end

      // Dropped-packet bit has no mask, so it never reaches the summary.
      assign in_sum[g]  = |(stat_q[g] & in_mask_q[g] & ~(32'h1 << `B_FIFO_EMPTY))
                          | (stat_q[g][`B_FIFO_EMPTY] & in_fifo_empty_mask_bits_q[g]);
      assign out_sum[g] = |(stat_q[g] & out_mask_q[g]);
    end
  endgenerate

  assign in_ep_irq_o  = in_sum & each_mask_q[N_EP-1:0];
  assign out_ep_irq_o = out_sum & each_mask_q[16 +: N_EP];

  // ---------------------------------------------------------------------------
  // Global masks
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_fifo_empty_mask_bits_q <= 16'h0000;
      each_mask_q               <= 32'h0000_0000;
    end
    else
    begin
      if (wr_i && addr_i == `OFF_FIFO_EMPTY_MASK)
        in_fifo_empty_mask_bits_q <= wdata_i[15:0];
      if (wr_i && addr_i == `OFF_EACH_MASK)
        each_mask_q <= wdata_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  reg [31:0] rd_mux;
  integer k;
  always @*
  begin
    rd_mux = 32'h0;
    if (addr_i == `OFF_FIFO_EMPTY_MASK)
      rd_mux = {16'h0, in_fifo_empty_mask_bits_q};
    else if (addr_i == `OFF_EACH_SUMMARY)
      rd_mux = {out_sum, in_sum};
    else if (addr_i == `OFF_EACH_MASK)
      rd_mux = each_mask_q;
    else if (addr_i == `OFF_EP0_IN_CTRL)
    begin
      rd_mux[`C_ENABLE]                = ep_enable_bit_q;
      rd_mux[`C_DISABLE]               = ep_disable_bit_q;
      rd_mux[`C_TX_FIFO]               = tx_fifo_select_q;
      rd_mux[`C_STALL]                 = stall_q;
      rd_mux[`C_KIND_HI:`C_KIND_LO]    = `KIND_CONTROL;
      rd_mux[`C_NAK_STATE]             = nak_state_flag_q;
      rd_mux[`C_ACTIVE]                = 1'b1;
      rd_mux[`C_NEXT_HI:`C_NEXT_LO]    = following_ep_field_q;
      rd_mux[`C_MPS_HI:`C_MPS_LO]      = max_packet_size_code_q;
    end
    else
      for (k = 0; k < N_EP; k = k + 1)
      begin
        if (addr_i == `OFF_IN_MASK_BASE + (k << `WORD_SH))
          rd_mux = in_mask_q[k];
        if (addr_i == `OFF_OUT_MASK_BASE + (k << `WORD_SH))
          rd_mux = out_mask_q[k];
        if (addr_i == `OFF_IN_STAT_BASE + (k << `STAT_STRIDE_SH))
          rd_mux = stat_q[k];
      end
  end

  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 32'h0;
    else if (rd_i)
      rdata_o <= rd_mux;
    else
      rdata_o <= 32'h0;
  end

endmodule

// ==== usb_host_model.sv ====
// Far-side stand-in that turns bench requests into one-cycle core event pulses.
`timescale 1ns/1ps
module usb_host_model (
  input  wire         clk_i,
  input  wire         go_i,
  input  wire [7:0]   sel_i,
  output reg  [239:0] ev_o,
  output reg          setup_o
);
  // Select value FF stands for a SETUP token; values 00 to EF each name one event line, F0 to FE name none.
  always @(posedge clk_i)
  begin
    ev_o <= 240'h0;
    setup_o <= go_i && sel_i == 8'hFF;
    if (go_i && sel_i != 8'hFF)
      ev_o[sel_i] <= 1'b1;
  end
endmodule

// ==== ep_intr_monitor.sv ====
// Concurrent checks on the endpoint-0 control ports of the endpoint interrupt block.
`timescale 1ns/1ps
module ep_intr_monitor (
  input wire        ref_clk_i,
  input wire        rst_b_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        setup_rcvd_i,
  input wire        ep0_disable_done_i,
  input wire        ep0_xfer_done_i,
  input wire        ep0_stall_o,
  input wire        ep0_nak_o,
  input wire        ep0_tx_allow_o,
  input wire [6:0]  ep0_max_bytes_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence ctrl_wr;
    wr_i && addr_i == 12'h900;
  endsequence
  sequence ctrl_rd;
    rd_i && addr_i == 12'h900;
  endsequence
  stall_wins_a: assert property (ep0_stall_o |-> !ep0_nak_o && !ep0_tx_allow_o)
    else $error("Stall did not override NAK.");
  setup_unstall_a: assert property (setup_rcvd_i |=> !ep0_stall_o)
    else $error("SETUP left stall set.");
  setup_nak_a: assert property (setup_rcvd_i |=> ep0_nak_o)
    else $error("SETUP did not set NAK.");
  set_nak_a: assert property (ctrl_wr ##0 wdata_i[27] |=> ep0_nak_o || ep0_stall_o)
    else $error("Set-NAK write had no effect.");
  clear_nak_a: assert property (ctrl_wr ##0 (wdata_i[26] && !wdata_i[27] && !setup_rcvd_i)
    |=> !ep0_nak_o) else $error("Clear-NAK write had no effect.");
  mps_decode_a: assert property (ctrl_wr |=> ep0_max_bytes_o == 7'h40 >> $past(wdata_i[1:0]))
    else $error("Packet size decode wrong.");
  done_stops_a: assert property (ep0_xfer_done_i |=> !ep0_tx_allow_o)
    else $error("Enable survived transfer done.");
  disabled_stops_a: assert property (ep0_disable_done_i |=> !ep0_tx_allow_o)
    else $error("Endpoint still sending after disable.");
  ctrl_fixed_a: assert property (ctrl_rd |=> rdata_o[15] && rdata_o[19:18] == 2'h0)
    else $error("Fixed control bits read wrong.");
endmodule

// ==== usb_device_ep_intr_ctrl_bench.sv ====
// Self-checking bench for the endpoint interrupt block against an integer model.
`timescale 1ns/1ps
module usb_device_ep_intr_ctrl_bench;
  localparam [95:0] AL = {12'h900, 12'hFFC, 12'h908, 12'h880, 12'h840, 12'h83C, 12'h838, 12'h834};
  reg          ref_clk_i, rst_b_i, wr_i, rd_i, go, ddone, xdone, per;
  reg  [11:0]  addr_i;
  reg  [31:0]  wdata_i, d;
  reg  [7:0]   sel;
  wire [31:0]  rdo;
  wire [239:0] ev;
  wire         setup, stl_o, nak_o, allow_o, fifo_o;
  wire [6:0]   mb_o;
  wire [3:0]   nx_o;
  wire [15:0]  iirq, oirq;
  integer      n_errors, checked, cyc, i, n, b, fe, em, en, dis, nak, stl, ctl;
  integer      im[0:15], om[0:15], st[0:15];
  usb_device_ep_intr_ctrl #(.N_EP(16)) uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdo),
    .ep_event_i(ev), .setup_rcvd_i(setup), .ep0_disable_done_i(ddone),
    .ep0_xfer_done_i(xdone), .ep0_periodic_i(per), .ep0_stall_o(stl_o), .ep0_nak_o(nak_o),
    .ep0_tx_allow_o(allow_o), .ep0_max_bytes_o(mb_o), .ep0_next_ep_o(nx_o),
    .ep0_tx_fifo_o(fifo_o), .in_ep_irq_o(iirq), .out_ep_irq_o(oirq));
  usb_host_model host (.clk_i(ref_clk_i), .go_i(go), .sel_i(sel), .ev_o(ev), .setup_o(setup));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  function [31:0] cexp();
    cexp = en << 31 | dis << 30 | stl << 21 | nak << 17 | 32'h8000 | ctl;
  endfunction
  function [31:0] sexp();
    integer k;
    begin
      sexp = 32'h0;
      for (k = 0; k < 16; k++)
      begin
        sexp[k] = |(st[k] & (im[k] | ((fe >> k) & 1) << 7));
        sexp[16 + k] = |(st[k] & om[k]);
      end
    end
  endfunction
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      checked = checked + 1;
      if (s !== e)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wrb(input [11:0] a, input [31:0] v);
    begin
      @(posedge ref_clk_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rdc(input [63:0] nm, input [11:0] a, input [31:0] e);
    begin
      @(posedge ref_clk_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk(nm, e, rdo);
    end
  endtask
  task outs();
    begin
      chk("stall", stl, stl_o);
      chk("nak", nak & !stl, nak_o);
      chk("allow", en & !dis & !nak & !stl, allow_o);
      chk("mps", 7'h40 >> ctl[1:0], mb_o);
      chk("next", ctl >> 11 & 15, nx_o);
      chk("fifo", ctl >> 22 & 1, fifo_o);
      chk("irq", sexp() & em, {oirq, iirq});
    end
  endtask
  task cw(input [31:0] v);
    begin
      wrb(12'h900, v | en << 31 | stl << 21);
      if (v[30] && en) dis = 1;
      if (v[31]) en = 1;
      if (v[21]) stl = 1;
      if (v[26]) nak = 0;
      if (v[26]) st[0] = st[0] & ~64;
      if (v[27]) nak = 1;
      ctl = v & 32'h00407803;
      rdc("ctrl", 12'h900, cexp());
      outs();
    end
  endtask
  task pulse(input [2:0] k, input [7:0] s);
    begin
      @(posedge ref_clk_i);
      {go, ddone, xdone, sel} <= {k, s};
      @(posedge ref_clk_i);
      {go, ddone, xdone} <= 3'h0;
      @(posedge ref_clk_i);
    end
  endtask
  task print_verdict();
    begin
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end
  initial
  begin
    {wr_i, rd_i, go, ddone, xdone, per, rst_b_i, addr_i, wdata_i, sel} = 59'h0;
    {n_errors, checked, cyc, fe, em, en, dis, nak, stl, ctl} = 320'h0;
    for (i = 0; i < 16; i++)
      {im[i], om[i], st[i]} = 96'h0;
    i = $urandom(32'h551BD7AE);
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 8; i++)
      rdc("reset", AL[i * 12 +: 12], i == 7 ? 32'h8000 : 32'h0);
    $display("test reset done");
    for (n = 0; n < 16; n++)
    begin
      d = $urandom;
      wrb(12'(12'h840 + 4 * n), d);
      im[n] = d & 32'h237F;
      rdc("in_mask", 12'(12'h840 + 4 * n), im[n]);
      d = $urandom;
      wrb(12'(12'h880 + 4 * n), d);
      om[n] = d & 32'h735F;
      rdc("out_mask", 12'(12'h880 + 4 * n), om[n]);
    end
    d = $urandom;
    wrb(12'h834, d);
    fe = d & 32'hFFFF;
    rdc("fe_mask", 12'h834, fe);
    d = $urandom;
    wrb(12'h83C, d);
    em = d;
    rdc("ep_mask", 12'h83C, em);
    wrb(12'hFFC, d);
    rdc("unmapped", 12'hFFC, 32'h0);
    $display("test masks done");
    for (i = 0; i < 40; i++)
    begin
      n = $urandom % 16;
      b = $urandom % 15;
      if (b == 10 || (n == 0 && b == 6)) b = 14;
      pulse(3'h4, 8'(n * 15 + b));
      st[n] = st[n] | 1 << b;
      rdc("status", 12'(12'h908 + 32 * n), st[n]);
      rdc("summary", 12'h838, sexp());
      outs();
      d = $urandom;
      wrb(12'(12'h908 + 32 * n), d);
      st[n] = st[n] & ~d;
      rdc("w1c", 12'(12'h908 + 32 * n), st[n]);
    end
    $display("test events done");
    d = $urandom;
    cw(d & 32'h00407803 | 32'h80000000);
    cw(32'h08000000);
    @(posedge ref_clk_i);
    per <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    per <= 1'b0;
    st[0] = st[0] | 64;
    rdc("nak_eff", 12'h908, st[0]);
    cw(32'h04000000);
    rdc("nak_eff", 12'h908, st[0]);
    cw(32'h00200000);
    cw(32'h08000000);
    pulse(3'h4, 8'hFF);
    {stl, nak} = 64'h1;
    rdc("ctrl", 12'h900, cexp());
    outs();
    cw(32'h40000000);
    pulse(3'h2, 8'h0);
    {en, dis} = 64'h0;
    st[0] = st[0] | 2;
    rdc("status", 12'h908, st[0]);
    rdc("ctrl", 12'h900, cexp());
    cw(32'h84000000);
    pulse(3'h1, 8'h0);
    en = 0;
    st[0] = st[0] | 1;
    rdc("status", 12'h908, st[0]);
    outs();
    cw(32'h40000000);
    for (i = 0; i < 4; i++)
      cw(i);
    $display("test ep0 done");
    print_verdict();
  end
endmodule
bind usb_device_ep_intr_ctrl ep_intr_monitor mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .setup_rcvd_i(setup_rcvd_i), .ep0_disable_done_i(ep0_disable_done_i),
  .ep0_xfer_done_i(ep0_xfer_done_i), .ep0_stall_o(ep0_stall_o), .ep0_nak_o(ep0_nak_o),
  .ep0_tx_allow_o(ep0_tx_allow_o), .ep0_max_bytes_o(ep0_max_bytes_o));
